// ---- inc/hcp_pkg.sv ----
// hcp_pkg: shared constants for the host control port, device and host ends
// assumes a 100 MHz mclk on both ends
package hcp_pkg;
  localparam int unsigned BYTE_BITS      = 8;
  localparam int unsigned CLK_PERIOD_NS  = 10;
  // strap sampling delay after reset release
  localparam int unsigned STRAP_DELAY_US = 1000;
  localparam int unsigned STRAP_CYCLES   = (STRAP_DELAY_US * 1000) / CLK_PERIOD_NS;
  // fixed upper address bits for the two-wire format
  localparam logic [4:0]  ADDR_UPPER     = 5'h07;
  localparam int unsigned ADDR_AD2_POS   = 2;
  localparam int unsigned ADDR_AD1_POS   = 1;
  // host serial clock half period in mclk cycles (minimum clock period 250 ns)
  localparam int unsigned SCK_HALF_NS    = 130;
  localparam int unsigned SCK_HALF_CYC   = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // select setup ahead of the clock burst
  localparam int unsigned SEL_SETUP_NS   = 100;
  localparam int unsigned SEL_SETUP_CYC  = (SEL_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  RESET_BYTE     = 8'h00;
endpackage

// ---- inc/hcp_if.sv ----
// hcp_if: the four-wire host control port link between host and device
// assumes the bench resolves the shared data wire from the enable
`timescale 1ns/10ps
`default_nettype none
interface hcp_if;
  logic sck;
  logic port_select_n;
  logic host_serial_in;
  logic host_serial_out_o;
  logic host_serial_out_oe;
  logic host_serial_out_i;
  modport dev  (input sck, port_select_n, host_serial_in, host_serial_out_i,
                output host_serial_out_o, host_serial_out_oe);
  modport host (output sck, port_select_n, host_serial_in,
                input host_serial_out_i);
endinterface
`default_nettype wire

// ---- rtl/hcp_device.sv ----
// hcp_device: slave end of the host control port, strap-selected format
// assumes link pins are asynchronous to mclk and the host drives the clock
// Operation
// - transfers move whole eight-bit bytes
// - port is slave only, never clocks
// - host makes clock and starts transfers
// - four-wire mode shifts out while shifting in
// - msb first, active while select low
// - sample input on rising serial clock
// - output changes on falling clock, msb at select
// - drive output while selected, else release
// - otherwise data pin acts open drain
// - strap high selects four-wire format
// - strap sampled 1 ms after reset
// - short bursts right-aligned, delivered at select rise
// - long bursts keep last eight bits
// - address straps form bits one and zero
`timescale 1ns/10ps
`default_nettype none
module hcp_device #(
  parameter int unsigned STRAP_CYCLES = hcp_pkg::STRAP_CYCLES
) (
  input  wire logic       mclk,
  input  wire logic       rstn,
  hcp_if.dev              link,
  input  wire logic       interface_select_strap,
  input  wire logic [7:0] tx_byte,
  output logic      [7:0] rx_byte,
  output logic            rx_valid,
  output logic            four_wire_mode,
  output logic            mode_ready,
  output logic      [6:0] slave_addr
);
  typedef enum logic [2:0] {
    HCP_MODE_WAIT = 3'b001,
    HCP_MODE_FOUR = 3'b010,
    HCP_MODE_TWO  = 3'b100
  } hcp_mode_t;

  hcp_mode_t   mode_reg;
  logic [2:0]  sck_sync_reg;
  logic [2:0]  sel_sync_reg;
  logic [1:0]  din_sync_reg;
  logic [1:0]  strap_sync_reg;
  logic [23:0] strap_cnt_reg;
  logic [7:0]  shift_in_reg;
  logic [7:0]  shift_out_reg;
  logic        out_bit_reg;
  logic [1:0]  addr_bits_reg;
  logic        strap_due;
  logic        sck_rise;
  logic        sck_fall;
  logic        sel_fall;
  logic        sel_rise;
  logic        selected;

  // one edge test for the synchronised clock and select pins, newer stage against the one before
  function automatic logic edge_of(input logic newer, input logic older,
                                   input logic to_high);
    return to_high ? (newer & ~older) : (~newer & older);
  endfunction

  // the strap moment is tested by two processes, so it is decoded once
  function automatic logic strap_take(input hcp_mode_t mode, input logic due);
    return (mode == HCP_MODE_WAIT) && due;
  endfunction

  assign sck_rise = edge_of(sck_sync_reg[1], sck_sync_reg[2], 1'b1);
  assign sck_fall = edge_of(sck_sync_reg[1], sck_sync_reg[2], 1'b0);
  assign sel_fall = edge_of(sel_sync_reg[1], sel_sync_reg[2], 1'b0);
  assign sel_rise = edge_of(sel_sync_reg[1], sel_sync_reg[2], 1'b1);
  assign selected = ~sel_sync_reg[1];

  // stage 0 feeds only stage 1; edges use stages 1 and 2, and the
  // clock resets to its idle low level so no false edge follows reset
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sck_sync_reg <= 3'h0;
    end else begin
      sck_sync_reg <= {sck_sync_reg[1:0], link.sck};
    end
  end

  // select resets high, its idle level
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sel_sync_reg <= 3'h7;
    end else begin
      sel_sync_reg <= {sel_sync_reg[1:0], link.port_select_n};
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      din_sync_reg <= 2'h0;
    end else begin
      din_sync_reg <= {din_sync_reg[0], link.host_serial_in};
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      strap_sync_reg <= 2'h0;
    end else begin
      strap_sync_reg <= {strap_sync_reg[0], interface_select_strap};
    end
  end

  // straps are read by a counter after release, never under reset, so a
  // strap that settles late in the reset pulse is still caught
  assign strap_due = (strap_cnt_reg >= 24'(STRAP_CYCLES - 1));

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      strap_cnt_reg <= 24'h000000;
    end else if (mode_reg == HCP_MODE_WAIT && !strap_due) begin
      strap_cnt_reg <= strap_cnt_reg + 24'h000001;
    end
  end

  // format is chosen once; only a reset brings the port back to waiting
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      mode_reg <= HCP_MODE_WAIT;
    end else begin
      case (mode_reg)
        HCP_MODE_WAIT: begin
          if (strap_take(mode_reg, strap_due)) begin
            mode_reg <= strap_sync_reg[1] ? HCP_MODE_FOUR : HCP_MODE_TWO;
          end
        end
        HCP_MODE_FOUR: begin
          mode_reg <= HCP_MODE_FOUR;
        end
        HCP_MODE_TWO: begin
          mode_reg <= HCP_MODE_TWO;
        end
        default: begin
          mode_reg <= HCP_MODE_WAIT;
        end
      endcase
    end
  end

  assign mode_ready     = (mode_reg != HCP_MODE_WAIT);
  assign four_wire_mode = (mode_reg == HCP_MODE_FOUR);

  // in two-wire format the data and select pins carry the address straps
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      addr_bits_reg <= 2'h0;
    end else if (strap_take(mode_reg, strap_due)) begin
      addr_bits_reg <= {sel_sync_reg[1], din_sync_reg[1]};
    end
  end

  assign slave_addr = {hcp_pkg::ADDR_UPPER, addr_bits_reg};

  // shift register keeps only the newest eight bits, so short bursts
  // end right-aligned and long ones keep the last byte
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      shift_in_reg <= hcp_pkg::RESET_BYTE;
    end else if (four_wire_mode) begin
      if (sel_fall) begin
        shift_in_reg <= hcp_pkg::RESET_BYTE;
      end else if (selected && sck_rise) begin
        shift_in_reg <= {shift_in_reg[6:0], din_sync_reg[1]};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rx_byte <= hcp_pkg::RESET_BYTE;
    end else if (four_wire_mode && sel_rise) begin
      rx_byte <= shift_in_reg;
    end
  end

  // strobe lasts one cycle whatever the length of the select pulse
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= four_wire_mode & sel_rise;
    end
  end

  // the whole byte is loaded at select fall; each rising clock then moves
  // the next bit to the top and takes in the received one, so once the
  // loaded byte runs out the received bits are echoed back
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      shift_out_reg <= hcp_pkg::RESET_BYTE;
    end else if (four_wire_mode) begin
      if (sel_fall) begin
        shift_out_reg <= tx_byte;
      end else if (selected && sck_rise) begin
        shift_out_reg <= {shift_out_reg[6:0], din_sync_reg[1]};
      end
    end
  end

  // the pin changes at select fall and then on each falling clock, after the host has sampled it
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      out_bit_reg <= 1'b1;
    end else if (four_wire_mode) begin
      if (sel_fall) begin
        out_bit_reg <= tx_byte[7];
      end else if (selected && sck_fall) begin
        out_bit_reg <= shift_out_reg[7];
      end
    end
  end

  // two-wire protocol engine lies outside this block; the pin there only
  // ever pulls low, so it is released here
  assign link.host_serial_out_o  = four_wire_mode ? out_bit_reg : 1'b0;
  assign link.host_serial_out_oe = four_wire_mode & selected;
endmodule
`default_nettype wire

// ---- rtl/hcp_host.sv ----
// hcp_host: master end of the four-wire host control port
// assumes the device samples on rising clock, with select setup and hold
`timescale 1ns/10ps
`default_nettype none
module hcp_host #(
  parameter int unsigned HALF_CYC = hcp_pkg::SCK_HALF_CYC
) (
  input  wire logic       mclk,
  input  wire logic       rstn,
  hcp_if.host             link,
  input  wire logic       start,
  input  wire logic [7:0] wr_byte,
  output logic            busy,
  output logic      [7:0] rd_byte,
  output logic            rd_valid
);
  typedef enum logic [3:0] {
    HCP_IDLE  = 4'h1,
    HCP_SETUP = 4'h2,
    HCP_LOW   = 4'h4,
    HCP_HIGH  = 4'h8
  } hcp_state_t;

  hcp_state_t  state_reg;
  logic [7:0]  cnt_reg;
  logic [3:0]  bit_reg;
  logic [7:0]  tx_reg;
  logic [7:0]  rx_reg;
  logic [1:0]  miso_sync_reg;

  assign busy = (state_reg != HCP_IDLE);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      miso_sync_reg <= 2'h3;
    end else begin
      miso_sync_reg <= {miso_sync_reg[0], link.host_serial_out_i};
    end
  end

  // host makes the clock by dividing mclk and starts every transfer
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_reg          <= HCP_IDLE;
      cnt_reg            <= 8'h00;
      bit_reg            <= 4'h0;
      tx_reg             <= 8'h00;
      rx_reg             <= 8'h00;
      rd_byte            <= 8'h00;
      rd_valid           <= 1'b0;
      link.sck           <= 1'b0;
      link.port_select_n <= 1'b1;
      link.host_serial_in <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      case (state_reg)
        HCP_IDLE: begin
          link.sck           <= 1'b0;
          link.port_select_n <= 1'b1;
          if (start) begin
            tx_reg              <= {wr_byte[6:0], 1'b0};
            link.host_serial_in <= wr_byte[7];
            link.port_select_n  <= 1'b0;
            cnt_reg             <= 8'h00;
            bit_reg             <= 4'h0;
            state_reg           <= HCP_SETUP;
          end
        end
        HCP_SETUP: begin
          // covers select setup and the device's msb presentation
          if (cnt_reg >= 8'(hcp_pkg::SEL_SETUP_CYC + HALF_CYC)) begin
            cnt_reg   <= 8'h00;
            link.sck  <= 1'b1;
            state_reg <= HCP_HIGH;
          end else begin
            cnt_reg <= cnt_reg + 8'h01;
          end
        end
        HCP_HIGH: begin
          if (cnt_reg == 8'h00) begin
            rx_reg <= {rx_reg[6:0], miso_sync_reg[1]};
          end
          if (cnt_reg >= 8'(HALF_CYC - 1)) begin
            cnt_reg  <= 8'h00;
            link.sck <= 1'b0;
            bit_reg  <= bit_reg + 4'h1;
            if (bit_reg == 4'(hcp_pkg::BYTE_BITS - 1)) begin
              state_reg <= HCP_IDLE;
              // with a one-cycle half period the last bit arrives in this cycle
              rd_byte   <= (cnt_reg == 8'h00) ? {rx_reg[6:0], miso_sync_reg[1]} : rx_reg;
              rd_valid  <= 1'b1;
              link.port_select_n <= 1'b1;
            end else begin
              state_reg <= HCP_LOW;
            end
          end else begin
            cnt_reg <= cnt_reg + 8'h01;
          end
        end
        HCP_LOW: begin
          if (cnt_reg == 8'h00) begin
            link.host_serial_in <= tx_reg[7];
            tx_reg              <= {tx_reg[6:0], 1'b0};
          end
          if (cnt_reg >= 8'(HALF_CYC - 1)) begin
            cnt_reg   <= 8'h00;
            link.sck  <= 1'b1;
            state_reg <= HCP_HIGH;
          end else begin
            cnt_reg <= cnt_reg + 8'h01;
          end
        end
        default: begin
          state_reg <= HCP_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- verification/hcp_assertions.sv ----
// hcp_assertions: wire checks on the host to device four-wire link
// assumes one mclk domain and a pull-up on the returned data wire
`timescale 1ns/10ps
`default_nettype none
module hcp_assertions (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic sck,
  input wire logic port_select_n,
  input wire logic host_serial_in,
  input wire logic host_serial_out_o,
  input wire logic host_serial_out_oe,
  input wire logic host_serial_out_i
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic [3:0] rise_reg;
  logic       sck_reg;
  // clock rises seen in the current frame, cleared while deselected
  always_ff @(posedge mclk) begin
    sck_reg <= sck;
    if (!rstn || port_select_n) rise_reg <= 4'h0;
    else if (sck && !sck_reg) rise_reg <= rise_reg + 4'h1;
  end
  sequence s_end; $rose(port_select_n); endsequence
  sequence s_off; ##[1:4] !host_serial_out_oe; endsequence
  property p_bits; s_end |-> rise_reg == 4'h8; endproperty
  property p_off; s_end |-> s_off; endproperty
  property p_on; $fell(port_select_n) |-> ##[1:4] host_serial_out_oe; endproperty
  property p_idle; port_select_n [*5] |-> !host_serial_out_oe; endproperty
  property p_noclk; port_select_n |-> !$rose(sck); endproperty
  property p_din; sck && $past(sck) |-> $stable(host_serial_in); endproperty
  property p_out;
    host_serial_out_oe && sck && $past(sck, 4) |-> $stable(host_serial_out_o);
  endproperty
  property p_wire;
    host_serial_out_oe |-> !$past(port_select_n, 2) && (host_serial_out_i == host_serial_out_o);
  endproperty
  a_bits: assert property (p_bits) else $error("frame clock count");
  a_off: assert property (p_off) else $error("output kept after deselect");
  a_on: assert property (p_on) else $error("output not driven");
  a_idle: assert property (p_idle) else $error("driven while idle");
  a_noclk: assert property (p_noclk) else $error("clock while idle");
  a_din: assert property (p_din) else $error("input moved in high phase");
  a_out: assert property (p_out) else $error("output moved in high phase");
  a_wire: assert property (p_wire) else $error("driven while deselected");
endmodule
`default_nettype wire

// ---- verification/tb_serial_host_interface.sv ----
// tb_serial_host_interface: host and device ends joined, plus a bench-driven device
// assumes a shortened strap delay and a 125 ns bench link clock
`timescale 1ns/10ps
`default_nettype none
module tb_serial_host_interface;
  localparam int unsigned SC = 20;
  logic       mclk = 1'b0, rstn = 1'b0, start = 1'b0, strap2 = 1'b0;
  logic [7:0] wr_byte = 8'h00, tx_byte = 8'h00, tx2 = 8'h00, rx_last = 8'h00;
  logic       busy, rd_valid, rx_valid, rx_valid2, fwm, fwm2, rdy, rdy2;
  logic [7:0] rd_byte, rx_byte, rx_byte2;
  logic [6:0] addr, addr2;
  int         fail_count = 0, cmp_count = 0, oe_hits = 0;
  int         nl[5] = '{1, 7, 8, 9, 13};
  logic [7:0] exp_q[$];
  hcp_if lk();
  hcp_if lk2();
  assign lk.host_serial_out_i = lk.host_serial_out_oe ? lk.host_serial_out_o : 1'b1;
  assign lk2.host_serial_out_i = lk2.host_serial_out_oe ? lk2.host_serial_out_o : 1'b1;
  always #5 mclk = ~mclk;
  // reference model: bytes the host sent, in order, against each delivered byte
  always @(posedge mclk) begin
    if (rx_valid === 1'b1) begin
      rx_last <= rx_byte;
      if (exp_q.size() > 0) check(rx_byte, exp_q.pop_front());
      else check(rx_valid, 1'b0);
    end
  end
  always @(posedge mclk) if (lk2.host_serial_out_oe === 1'b1) oe_hits++;
  hcp_host u_hcp_host (.mclk(mclk), .rstn(rstn), .link(lk.host), .start(start),
    .wr_byte(wr_byte), .busy(busy), .rd_byte(rd_byte), .rd_valid(rd_valid));
  hcp_device #(.STRAP_CYCLES(SC)) u_hcp_device (.mclk(mclk), .rstn(rstn), .link(lk.dev),
    .interface_select_strap(1'b1), .tx_byte(tx_byte), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .four_wire_mode(fwm), .mode_ready(rdy), .slave_addr(addr));
  hcp_device #(.STRAP_CYCLES(SC)) u_hcp_device_b (.mclk(mclk), .rstn(rstn),
    .link(lk2.dev), .interface_select_strap(strap2), .tx_byte(tx2), .rx_byte(rx_byte2),
    .rx_valid(rx_valid2), .four_wire_mode(fwm2), .mode_ready(rdy2), .slave_addr(addr2));
  hcp_assertions u_hcp_assertions (.mclk(mclk), .rstn(rstn), .sck(lk.sck),
    .port_select_n(lk.port_select_n), .host_serial_in(lk.host_serial_in),
    .host_serial_out_o(lk.host_serial_out_o), .host_serial_out_oe(lk.host_serial_out_oe),
    .host_serial_out_i(lk.host_serial_out_i));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("mismatches %0d, compares %0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function automatic logic flag(input int w);
    case (w)
      0: return rd_valid;
      1: return rx_valid2;
      2: return rdy2;
      default: return ~busy;
    endcase
  endfunction
  // every wait is bounded; running out ends the run as a failure
  task automatic await(input int w, input int lim);
    int n;
    n = 0;
    while (flag(w) !== 1'b1) begin
      @(posedge mclk);
      #1;
      n++;
      if (n > lim) begin
        fail_count++;
        print_verdict();
      end
    end
  endtask
  task automatic do_reset(input logic s2);
    logic a2, a1;
    a2 = $urandom;
    a1 = $urandom;
    rstn = 1'b0;
    strap2 = s2;
    lk2.port_select_n = a2;
    lk2.host_serial_in = a1;
    repeat (2) @(posedge mclk);
    #1;
    rstn = 1'b1;
    repeat (SC - 3) @(posedge mclk);
    #1;
    check(rdy2, 1'b0);
    await(2, 8);
    check(fwm2, s2);
    check(addr2, {5'h07, a2, a1});
    lk2.port_select_n = 1'b1;
    lk2.host_serial_in = 1'b0;
  endtask
  // bench link clock stands still between frames
  task automatic burst(input int n);
    logic [15:0] v, m;
    logic [7:0]  t;
    v = $urandom;
    t = $urandom;
    tx2 = t;
    m = (n >= 8) ? 16'h00ff : (16'h0001 << n) - 16'h0001;
    lk2.port_select_n = 1'b0;
    #100;
    for (int i = 0; i < n; i++) begin
      lk2.host_serial_in = v[n-1-i];
      #62.5;
      if (strap2) check(lk2.host_serial_out_i, (i < 8) ? t[7-i] : v[n+7-i]);
      lk2.sck = 1'b1;
      #62.5;
      lk2.sck = 1'b0;
    end
    #62.5;
    lk2.port_select_n = 1'b1;
    if (strap2) begin
      await(1, 20);
      check(rx_byte2 & m, v & m);
      @(posedge mclk);
      #1;
      check(rx_valid2, 1'b0);
    end
    #100;
  endtask
  task automatic xfer();
    logic [7:0] w, t;
    w = $urandom;
    t = $urandom;
    await(3, 10);
    wr_byte = w;
    tx_byte = t;
    exp_q.push_back(w);
    start = 1'b1;
    @(posedge mclk);
    #1;
    start = 1'b0;
    await(0, 600);
    check(rd_byte, t);
    repeat (8) @(posedge mclk);
    #1;
    check(rx_last, w);
  endtask
  initial begin
    lk2.sck = 1'b0;
    lk2.port_select_n = 1'b1;
    lk2.host_serial_in = 1'b0;
    void'($urandom(32'h6e58d5f6));
    do_reset(1'b0);
    burst(8);
    check(oe_hits, 16'h0000);
    do_reset(1'b1);
    check(rdy & fwm, 1'b1);
    check(addr, {5'h07, 2'h2});
    for (int k = 0; k < 6; k++) xfer();
    foreach (nl[j]) burst(nl[j]);
    print_verdict();
  end
endmodule
`default_nettype wire
